// File: src/sync_pin_pkg.sv
// Constants and types shared by the sync pin configuration block
`default_nettype none
package sync_pin_pkg;
   localparam logic [7:0] addr_config_one  = 8'h01;
   localparam logic [7:0] addr_polarity    = 8'h02;
   localparam logic [7:0] addr_alarm_mask  = 8'h03;
   localparam logic [7:0] addr_alarm_stat  = 8'h04;
   localparam logic [7:0] addr_line_mode   = 8'h05;
   localparam logic [7:0] cfg_reset        = 8'h00;
   localparam logic [7:0] cfg_one_used     = 8'h7f;
   localparam logic [7:0] polarity_used    = 8'hf0;
   localparam int bit_out_format  = 0;
   localparam int bit_tx_dir      = 1;
   localparam int bit_tx_mf       = 2;
   localparam int bit_cc_ref      = 3;
   localparam int bit_loss_func   = 4;
   localparam int bit_rx_mode_a   = 5;
   localparam int bit_rx_mode_b   = 6;
   localparam int bit_tx_sync_inv = 4;
   localparam int bit_rx_sync_inv = 5;
   localparam int bit_tx_clk_inv  = 6;
   localparam int bit_rx_clk_inv  = 7;
   localparam logic [1:0] mode_t1 = 2'h0;
   localparam logic [1:0] mode_e1 = 2'h1;
   localparam logic [1:0] mode_cc = 2'h2;
   localparam logic [1:0] mode_hs = 2'h3;
   localparam logic [5:0] ahb_word_addr = 6'h3f;
   localparam logic [2:0] line_clk_half = 3'h3;
   typedef enum logic [1:0] {
      bus_idle  = 2'b00,
      bus_addr  = 2'b01,
      bus_data  = 2'b11
   } bus_state_type;
endpackage
`default_nettype wire

// File: src/sync_pin_if.sv
// Link between the device end and the system logic end
`timescale 1ns/100ps
`default_nettype none
interface sync_pin_if;
   logic tx_sync_dev_o;
   logic tx_sync_dev_oe;
   logic tx_sync_sys_o;
   logic rx_sync_pin;
   logic frame_loss_pin;
   logic tx_data_pos;
   logic tx_data_neg;
   logic tx_clock_pin;
   logic rx_clock_pin;
   wire  tx_sync_pin = tx_sync_dev_oe ? tx_sync_dev_o : tx_sync_sys_o;
   modport device (
      input  tx_sync_pin,
      output tx_sync_dev_o,
      output tx_sync_dev_oe,
      output rx_sync_pin,
      output frame_loss_pin,
      output tx_data_pos,
      output tx_data_neg,
      input  tx_clock_pin,
      input  rx_clock_pin
   );
   modport system (
      input  tx_sync_pin,
      input  tx_sync_dev_oe,
      output tx_sync_sys_o,
      input  rx_sync_pin,
      input  frame_loss_pin,
      input  tx_data_pos,
      input  tx_data_neg,
      output tx_clock_pin,
      output rx_clock_pin
   );
endinterface
`default_nettype wire

// File: src/pin_sync2.sv
// Two-flop synchroniser with edge flags taken from the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_sync2 (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic last;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta  <= 1'b0;
         level <= 1'b0;
         last  <= 1'b0;
      end else begin
         meta  <= async_in;
         level <= meta;
         last  <= level;
      end
   end
   assign rise = level & ~last;
   assign fall = ~level & last;
endmodule
`default_nettype wire

// File: src/sync_pin_device.sv
// Device end: AHB-Lite registers, alarm interrupts and sync pin muxing
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sync_pin_device
   import sync_pin_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   sync_pin_if.device       link,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   input  wire logic        rx_frame_loss,
   input  wire logic        rx_signal_loss,
   input  wire logic        rx_alarm_indication,
   input  wire logic        rx_yellow_alarm,
   input  wire logic        tx_clock_loss,
   input  wire logic        cc_error,
   input  wire logic        tx_sync_evt,
   input  wire logic        tx_mf_evt,
   input  wire logic        tx_cc_400_evt,
   input  wire logic        tx_signaling,
   input  wire logic        rx_frame_evt,
   input  wire logic        rx_cas_mf_evt,
   input  wire logic        rx_crc_mf_evt,
   input  wire logic        rx_signaling,
   input  wire logic        tx_bipolar_pos,
   input  wire logic        tx_bipolar_neg,
   input  wire logic        tx_nrz,
   output logic             tx_sync_in,
   output logic             tx_clock_edge,
   output logic             rx_clock_edge
);
   logic [7:0] io_pin_config_one;
   logic [7:0] io_pin_polarity;
   logic [7:0] alarm_interrupt_mask;
   logic [7:0] alarm_status;
   logic [1:0] line_mode;
   logic [3:0] cond_last;
   logic [7:0] next_status;
   logic       wr_pend;
   logic       rd_pend;
   logic [7:0] wr_addr;
   logic       tx_wide;
   logic       rx_wide;
   logic       rx_pulse_q;
   logic       tx_pulse_q;
   logic       tx_sync_lvl;
   logic       tx_clk_lvl;
   logic       rx_clk_lvl;
   logic       tx_clk_rise;
   logic       tx_clk_fall;
   logic       rx_clk_rise;
   logic       rx_clk_fall;

   pin_sync2 u_tx_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (link.tx_sync_pin),
      .level    (tx_sync_lvl),
      .rise     (),
      .fall     ()
   );
   pin_sync2 u_tx_clk (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (link.tx_clock_pin),
      .level    (tx_clk_lvl),
      .rise     (tx_clk_rise),
      .fall     (tx_clk_fall)
   );
   pin_sync2 u_rx_clk (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (link.rx_clock_pin),
      .level    (rx_clk_lvl),
      .rise     (rx_clk_rise),
      .fall     (rx_clk_fall)
   );

   wire is_t1 = line_mode == mode_t1;
   wire is_e1 = line_mode == mode_e1;
   wire is_cc = line_mode == mode_cc;

   // Clock inversion picks which synchronised edge acts as the active one
   assign tx_clock_edge = io_pin_polarity[bit_tx_clk_inv] ?
                          tx_clk_fall : tx_clk_rise;
   assign rx_clock_edge = io_pin_polarity[bit_rx_clk_inv] ?
                          rx_clk_fall : rx_clk_rise;

   // Bus decode: one aligned word per register
   wire        bus_take = hsel & hready & htrans[1];
   wire [7:0]  word_sel = {2'b00, haddr[7:2] & ahb_word_addr};
   wire [7:0]  wbyte    = hwdata[7:0];
   wire        rd_stat  = bus_take & ~hwrite & (word_sel == addr_alarm_stat);
   wire [7:0]  rd_mux   =
      (word_sel == addr_config_one) ? io_pin_config_one :
      (word_sel == addr_polarity)   ? io_pin_polarity :
      (word_sel == addr_alarm_mask) ? alarm_interrupt_mask :
      (word_sel == addr_alarm_stat) ? alarm_status :
      (word_sel == addr_line_mode)  ? {6'h00, line_mode} : cfg_reset;

   // Condition bits follow live; clear events latch on falling edges
   wire [3:0] cond_now  = {rx_yellow_alarm, rx_alarm_indication,
                           rx_signal_loss, rx_frame_loss};
   wire [3:0] cond_rise = cond_now & ~cond_last;
   wire [3:0] cond_fall = ~cond_now & cond_last;
   // Read clears latched bits, a same-cycle event still wins
   assign next_status = {(rd_stat ? 4'h0 : alarm_status[7:4]) | cond_fall,
                         cond_now};
   // Conditions interrupt on rising edge only, clear events while latched
   wire irq_cond = |(cond_rise & alarm_interrupt_mask[3:0]);
   wire irq_clr  = |(alarm_status[7:4] & alarm_interrupt_mask[7:4]);
   logic      irq_hold;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         io_pin_config_one    <= cfg_reset;
         io_pin_polarity      <= cfg_reset;
         alarm_interrupt_mask <= cfg_reset;
         line_mode            <= mode_t1;
         wr_pend              <= 1'b0;
         wr_addr              <= cfg_reset;
      end else begin
         wr_pend <= bus_take & hwrite;
         wr_addr <= word_sel;
         if (wr_pend) begin
            // Unused bits kept at zero whatever software writes
            if (wr_addr == addr_config_one)
               io_pin_config_one <= wbyte & cfg_one_used;
            if (wr_addr == addr_polarity)
               io_pin_polarity <= wbyte & polarity_used;
            if (wr_addr == addr_alarm_mask)
               alarm_interrupt_mask <= wbyte;
            if (wr_addr == addr_line_mode)
               line_mode <= wbyte[1:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         alarm_status <= cfg_reset;
         cond_last    <= 4'h0;
         irq_hold     <= 1'b0;
         hrdata       <= 32'h0000_0000;
         rd_pend      <= 1'b0;
      end else begin
         alarm_status <= next_status;
         cond_last    <= cond_now;
         // Condition edge interrupt held until status read
         irq_hold     <= (irq_hold & ~rd_stat) | irq_cond;
         rd_pend      <= bus_take & ~hwrite;
         if (bus_take & ~hwrite)
            hrdata <= {24'h00_0000, rd_mux};
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = irq_hold | irq_clr;

   // Transmit sync pin: direction, then function, then polarity
   wire tx_dir  = io_pin_config_one[bit_tx_dir];
   wire tx_mf   = io_pin_config_one[bit_tx_mf];
   wire cc_sel  = io_pin_config_one[bit_cc_ref];
   wire tx_base = is_cc ? (cc_sel ? tx_cc_400_evt : tx_sync_evt) :
                  (tx_mf ? tx_mf_evt : tx_sync_evt);
   assign tx_wide = is_t1 & cc_sel & tx_dir & tx_signaling;
   wire tx_func = tx_base | (tx_wide & tx_pulse_q);
   wire rx_a    = io_pin_config_one[bit_rx_mode_a];
   wire rx_b    = io_pin_config_one[bit_rx_mode_b];
   wire rx_mf   = (is_e1 & rx_b) ? rx_crc_mf_evt : rx_cas_mf_evt;
   wire rx_base = rx_a ? rx_mf : rx_frame_evt;
   assign rx_wide = is_t1 & ~rx_a & rx_b & rx_signaling;
   wire rx_func = rx_base | (rx_wide & rx_pulse_q);
   wire loss_sel = io_pin_config_one[bit_loss_func];
   wire loss_func = is_cc ? (~loss_sel & cc_error) :
                    (loss_sel ? tx_clock_loss : rx_frame_loss);
   wire fmt_nrz = io_pin_config_one[bit_out_format];
   wire tx_sync_invert = io_pin_polarity[bit_tx_sync_inv];
   wire rx_sync_invert = io_pin_polarity[bit_rx_sync_inv];

   // Registered pin drivers; inversion last so width and rate survive
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_pulse_q          <= 1'b0;
         rx_pulse_q          <= 1'b0;
         link.tx_sync_dev_o  <= 1'b0;
         link.tx_sync_dev_oe <= 1'b0;
         link.rx_sync_pin    <= 1'b0;
         link.frame_loss_pin <= 1'b0;
         link.tx_data_pos    <= 1'b0;
         link.tx_data_neg    <= 1'b0;
         tx_sync_in          <= 1'b0;
      end else begin
         tx_pulse_q          <= tx_base;
         rx_pulse_q          <= rx_base;
         link.tx_sync_dev_oe <= tx_dir;
         link.tx_sync_dev_o  <= tx_func ^ tx_sync_invert;
         link.rx_sync_pin    <= rx_func ^ rx_sync_invert;
         link.frame_loss_pin <= loss_func;
         link.tx_data_pos    <= fmt_nrz ? tx_nrz : tx_bipolar_pos;
         link.tx_data_neg    <= fmt_nrz ? 1'b0 : tx_bipolar_neg;
         tx_sync_in          <= ~tx_dir & (tx_sync_lvl ^
                                io_pin_polarity[bit_tx_sync_inv]);
      end
   end
endmodule
`default_nettype wire

// File: src/sync_pin_system.sv
// System logic end: makes the line clocks and the input sync
`timescale 1ns/100ps
`default_nettype none
module sync_pin_system
   import sync_pin_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst,
   sync_pin_if.system link,
   input  wire logic sync_req,
   output logic      rx_sync_seen,
   output logic      frame_loss_seen,
   output logic      tx_sync_seen
);
   logic [2:0] div_cnt;
   logic       line_clk;
   logic       rx_lvl;
   logic       loss_lvl;
   logic       tx_lvl;
   pin_sync2 u_rx (
      .core_clk (core_clk), .rst (rst), .async_in (link.rx_sync_pin),
      .level (rx_lvl), .rise (), .fall ());
   pin_sync2 u_loss (
      .core_clk (core_clk), .rst (rst), .async_in (link.frame_loss_pin),
      .level (loss_lvl), .rise (), .fall ());
   pin_sync2 u_tx (
      .core_clk (core_clk), .rst (rst), .async_in (link.tx_sync_pin),
      .level (tx_lvl), .rise (), .fall ());
   // Divider makes a 160 ns line clock from the 20 ns core clock
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_cnt            <= 3'h0;
         line_clk           <= 1'b0;
         link.tx_sync_sys_o <= 1'b0;
      end else begin
         div_cnt <= (div_cnt == line_clk_half) ? 3'h0 : div_cnt + 3'h1;
         if (div_cnt == line_clk_half)
            line_clk <= ~line_clk;
         // Software keeps mode bits legal; system only drives when device listens
         link.tx_sync_sys_o <= sync_req & ~link.tx_sync_dev_oe;
      end
   end
   assign link.tx_clock_pin = line_clk;
   assign link.rx_clock_pin = line_clk;
   assign rx_sync_seen      = rx_lvl;
   assign frame_loss_seen   = loss_lvl;
   assign tx_sync_seen      = tx_lvl;
endmodule
`default_nettype wire

// File: testbench/sync_pin_asserts.sv
// Checker on the link pins and the register writes that steer them
`timescale 1ns/100ps
`default_nettype none
module sync_pin_asserts
   import sync_pin_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        irq,
   input wire logic        rx_frame_loss,
   input wire logic        tx_clock_loss,
   input wire logic        cc_error,
   input wire logic        tx_sync_evt,
   input wire logic        rx_frame_evt,
   input wire logic        tx_bipolar_pos,
   input wire logic        tx_nrz,
   input wire logic        tx_sync_dev_o,
   input wire logic        tx_sync_dev_oe,
   input wire logic        rx_sync_pin,
   input wire logic        frame_loss_pin,
   input wire logic        tx_data_pos,
   input wire logic        tx_data_neg
);
   logic        wr_pend;
   logic [7:0]  wr_idx;
   logic [7:0]  cfg;
   logic [7:0]  pol;
   logic [7:0]  mask;
   logic [1:0]  mode;
   logic [17:0] prev;
   wire  [7:0]  wd = hwdata[7:0];
   // Pin checks only hold once the shadow settings stopped moving
   wire         steady = prev == {cfg, pol, mode};
   always_ff @(posedge core_clk) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_idx  <= {2'h0, haddr[7:2]};
      prev    <= {cfg, pol, mode};
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg  <= 8'h00;
         pol  <= 8'h00;
         mask <= 8'h00;
         mode <= 2'h0;
      end else if (wr_pend) begin
         if (wr_idx == addr_config_one) cfg <= wd & cfg_one_used;
         if (wr_idx == addr_polarity) pol <= wd & polarity_used;
         if (wr_idx == addr_alarm_mask) mask <= wd;
         if (wr_idx == addr_line_mode) mode <= wd[1:0];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_nrz_format: assert property (
      steady && cfg[0] |-> tx_data_pos == $past(tx_nrz) && !tx_data_neg)
      else $error("nrz format pins wrong");
   a_bipolar_format: assert property (
      steady && !cfg[0] |-> tx_data_pos == $past(tx_bipolar_pos))
      else $error("bipolar format pin wrong");
   a_sync_dir: assert property (
      steady |-> tx_sync_dev_oe == cfg[1])
      else $error("tx sync direction wrong");
   a_loss_pin: assert property (
      steady && (!mode[1] || mode == mode_cc && !cfg[4]) |->
      frame_loss_pin == (mode == mode_cc ? $past(cc_error) :
         cfg[4] ? $past(tx_clock_loss) : $past(rx_frame_loss)))
      else $error("frame loss pin function wrong");
   a_rx_frame: assert property (
      steady && !mode[1] && cfg[6:5] == 2'b00 |->
      rx_sync_pin == ($past(rx_frame_evt) ^ pol[5]))
      else $error("rx frame sync wrong");
   a_tx_frame: assert property (
      steady && tx_sync_dev_oe && !mode[1] && cfg[3:2] == 2'b00 |->
      tx_sync_dev_o == ($past(tx_sync_evt) ^ pol[4]))
      else $error("tx frame sync wrong");
   a_cond_irq: assert property (
      mask[0] && $rose(rx_frame_loss) |-> ##[1:3] irq)
      else $error("condition edge gave no irq");
   a_clear_irq: assert property (
      mask[4] && $fell(rx_frame_loss) |-> ##[1:3] irq)
      else $error("clear event gave no irq");
   a_mask_quiet: assert property (
      mask == 8'h00 && $past(mask) == 8'h00 && !$past(irq) |-> !irq)
      else $error("irq rose while all masked");
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Bench joining both ends over the link, driven through AHB-Lite
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import sync_pin_pkg::*;
;
   logic        core_clk;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        irq;
   logic        tx_sync_in;
   logic        frame_loss_seen;
   logic        rx_sync_seen;
   logic        tx_sync_seen;
   logic [17:0] st;
   logic [31:0] q;
   int          err_total;
   int          checked;
   int          cnt;
   // cfg, pol, mode, event-6, then tx pin, signaling, two expected levels
   localparam logic [31:0] cases [11] = '{32'h06000112, 32'h02000110,
      32'h0a002212, 32'h02002210, 32'h0a00001b, 32'h4000040b,
      32'h20001502, 32'h60001602, 32'h60001500, 32'h00200401, 32'h02100011};
   sync_pin_if link_if ();
   sync_pin_device u_sync_pin_device (
      .core_clk(core_clk), .rst(rst), .link(link_if), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(), .irq(irq),
      .rx_frame_loss(st[0]), .rx_signal_loss(st[1]),
      .rx_alarm_indication(st[2]), .rx_yellow_alarm(st[3]),
      .tx_clock_loss(st[4]), .cc_error(st[5]), .tx_sync_evt(st[6]),
      .tx_mf_evt(st[7]), .tx_cc_400_evt(st[8]), .tx_signaling(st[9]),
      .rx_frame_evt(st[10]), .rx_cas_mf_evt(st[11]),
      .rx_crc_mf_evt(st[12]), .rx_signaling(st[13]),
      .tx_bipolar_pos(st[14]), .tx_bipolar_neg(st[15]), .tx_nrz(st[16]),
      .tx_sync_in(tx_sync_in), .tx_clock_edge(), .rx_clock_edge());
   sync_pin_system u_sync_pin_system (
      .core_clk(core_clk), .rst(rst), .link(link_if), .sync_req(st[17]),
      .rx_sync_seen(rx_sync_seen), .frame_loss_seen(frame_loss_seen),
      .tx_sync_seen(tx_sync_seen));
   sync_pin_asserts u_sync_pin_asserts (
      .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .irq(irq),
      .rx_frame_loss(st[0]), .tx_clock_loss(st[4]), .cc_error(st[5]),
      .tx_sync_evt(st[6]), .rx_frame_evt(st[10]),
      .tx_bipolar_pos(st[14]), .tx_nrz(st[16]),
      .tx_sync_dev_o(link_if.tx_sync_dev_o),
      .tx_sync_dev_oe(link_if.tx_sync_dev_oe),
      .rx_sync_pin(link_if.rx_sync_pin),
      .frame_loss_pin(link_if.frame_loss_pin),
      .tx_data_pos(link_if.tx_data_pos), .tx_data_neg(link_if.tx_data_neg));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Waits are open ended on purpose; only the watchdog ends a hang
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge core_clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a[5:0], 2'b00};
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk("register", e, q);
   endtask
   task automatic run_case(input logic [31:0] e);
      int k;
      k = int'(e[11:8]) + 6;
      wr(addr_line_mode, {28'h0, e[15:12]});
      wr(addr_config_one, {24'h0, e[31:24]});
      wr(addr_polarity, {24'h0, e[23:16]});
      st[9]  <= e[3];
      st[13] <= e[3];
      repeat (4) @(posedge core_clk);
      st[k] <= 1'b1;
      @(posedge core_clk);
      st[k] <= 1'b0;
      for (int j = 1; j >= 0; j--) begin
         #1;
         chk("sync pin", {31'h0, e[j]}, {31'h0, e[4] ?
            link_if.tx_sync_pin : link_if.rx_sync_pin});
         @(posedge core_clk);
      end
      // Far end sees the first pin level two flops later
      #1;
      chk("seen pin", {31'h0, e[1]}, {31'h0, e[4] ?
         tx_sync_seen : rx_sync_seen});
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      st = 18'h0;
      err_total = 0;
      checked = 0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 1; i < 6; i++)
         rd(8'(i), 32'h0);
      chk("sync oe", 32'h0, {31'h0, link_if.tx_sync_dev_oe});
      wr(8'h07, 32'hff);
      rd(8'h07, 32'h0);
      wr(addr_config_one, 32'h7f);
      rd(addr_config_one, 32'h7f);
      wr(addr_polarity, 32'hf0);
      rd(addr_polarity, 32'hf0);
      wr(addr_alarm_mask, 32'hff);
      rd(addr_alarm_mask, 32'hff);
      // Inverted pass wants falling edges only, plain pass rising only
      for (int p = 0; p < 2; p++) begin
         cnt = 0;
         repeat (200) begin
            wait_n(1);
            cnt += int'({u_sync_pin_device.tx_clock_edge,
                         u_sync_pin_device.tx_clk_lvl} === {1'b1, p == 1});
            cnt += int'({u_sync_pin_device.rx_clock_edge,
                         u_sync_pin_device.rx_clk_lvl} === {1'b1, p == 1});
         end
         chk("clock edges", 32'h1, {31'h0, cnt >= 48 && cnt <= 52});
         wr(addr_polarity, 32'h0);
      end
      wr(addr_config_one, 32'h0);
      st[16:14] <= 3'b110;
      wait_n(3);
      chk("data", 32'h1,
          {30'h0, link_if.tx_data_pos, link_if.tx_data_neg});
      wr(addr_config_one, 32'h1);
      wait_n(3);
      chk("data", 32'h2,
          {30'h0, link_if.tx_data_pos, link_if.tx_data_neg});
      wr(addr_config_one, 32'h0);
      st[16:14] <= 3'b000;
      st[0] <= 1'b1;
      wait_n(6);
      chk("loss pin", 32'h1, {31'h0, frame_loss_seen});
      wr(addr_config_one, 32'h10);
      wait_n(6);
      chk("loss pin", 32'h0, {31'h0, frame_loss_seen});
      wr(addr_config_one, 32'h0);
      wr(addr_line_mode, 32'h2);
      st[0] <= 1'b0;
      st[5] <= 1'b1;
      wait_n(6);
      chk("loss pin", 32'h1, {31'h0, frame_loss_seen});
      wr(addr_line_mode, 32'h0);
      st[5] <= 1'b0;
      st[17] <= 1'b1;
      wait_n(8);
      chk("sync input", 32'h1, {31'h0, tx_sync_in});
      wr(addr_polarity, 32'h10);
      wr(addr_config_one, 32'h2);
      st[17] <= 1'b0;
      wait_n(8);
      chk("sync output", 32'h1, {31'h0, tx_sync_seen});
      wr(addr_alarm_mask, 32'h0);
      rd(addr_alarm_stat, 32'h10);
      st[3] <= 1'b1;
      wait_n(4);
      chk("irq", 32'h0, {31'h0, irq});
      rd(addr_alarm_stat, 32'h8);
      st[3] <= 1'b0;
      wait_n(4);
      chk("irq", 32'h0, {31'h0, irq});
      rd(addr_alarm_stat, 32'h80);
      rd(addr_alarm_stat, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(addr_alarm_mask, 32'h1 << i);
         st[i] <= 1'b1;
         wait_n(4);
         chk("irq", 32'h1, {31'h0, irq});
         rd(addr_alarm_stat, 32'h1 << i);
         wait_n(2);
         chk("irq", 32'h0, {31'h0, irq});
         wr(addr_alarm_mask, 32'h10 << i);
         st[i] <= 1'b0;
         wait_n(4);
         chk("irq", 32'h1, {31'h0, irq});
         rd(addr_alarm_stat, 32'h10 << i);
         wait_n(2);
         chk("irq", 32'h0, {31'h0, irq});
      end
      foreach (cases[i])
         run_case(cases[i]);
      summarize();
   end
endmodule
`default_nettype wire
